// ### rtl/bmr_defs.vh
`ifndef BMR_DEFS_VH
`define BMR_DEFS_VH

// Instruction word fields
`define OPC_HI          31
`define OPC_LO          24
`define FLD_C_HI        23
`define FLD_C_LO        16
`define FLD_A_HI        15
`define FLD_A_LO        8
`define FLD_B_HI        7
`define FLD_B_LO        0

// Opcode encodings
`define OP_CALL         8'hA8
`define OP_SUBROUTINE_CALL_INDIRECT_OP        8'hC8
`define OP_JMP          8'hA0
`define OP_JMPI         8'hC0
`define OP_JUMP_ON_TRUE_OP         8'hAC
`define OP_JUMP_ON_TRUE_INDIRECT_OP        8'hCC
`define OP_JUMP_ON_FALSE_OP         8'hA4
`define OP_JUMP_ON_FALSE_INDIRECT_OP        8'hC4
`define OP_JUMP_FALSE_DECREMENT_OP      8'hB4
`define OP_CLZ          8'h08
`define OP_LOAD_POINTER_TRIPLE_OP        8'h9E
`define OP_EMULATION_TRAP_OP      8'hD7
`define OP_INV          8'h9F
`define OP_INTERRUPT_RETURN_OP         8'h88
`define OP_INTERRUPT_RETURN_COMPAT_OP      8'h8C
`define OP_HALT         8'h89
`define OP_FEQ          8'hEB
`define OP_DEQ          8'hF1
`define OP_FGE          8'hEF
`define OP_DGE          8'hF5
`define OP_FGT          8'hEC
`define OP_DGT          8'hF2
`define OP_FP_LO        8'hE0
`define OP_FP_HI        8'hF7

// Boolean encoding and call link offset
`define BOOL_TRUE       32'h8000_0000
`define BOOL_FALSE      32'h0000_0000
`define LINK_OFFSET     32'h0000_0008

// Register numbering
`define REG_INDIRECT    8'h00
`define REG_STACK       8'h01
`define REG_GLOBAL_BASE 8'h40
`define GPR_WORDS       192

// Reset values
`define RST_PTR         8'h00
`define RST_WORD        32'h0000_0000

// Base of the trap vectors taken by emulated floating-point opcodes (base plus opcode minus OP_FP_LO)
`define FP_TRAP_VEC_BASE 8'h20

`endif

// ### rtl/leading_zero_count.v
`timescale 1ns/1ns
// Counts zeros above the highest set bit; an all-zero word yields WIDTH
module leading_zero_count #(
  parameter WIDTH = 32,
  parameter CW    = 6
) (
  input  wire [WIDTH-1:0] word_i,
  output reg  [CW-1:0]    count_o
);
  integer i;
  reg     found;

  // Scan from the top; first one stops the count
  always @*
  begin
    count_o = {CW{1'b0}};
    found   = 1'b0;
    for (i = WIDTH - 1; i >= 0; i = i - 1)
    begin
      if (!found && !word_i[i])
        count_o = count_o + 1'b1;
      else
        found = 1'b1;
    end
  end
endmodule // leading_zero_count

// ### rtl/reg_number_map.v
`timescale 1ns/1ns
`include "bmr_defs.vh"
// Turns an instruction register number into an absolute register number
module reg_number_map (
  input  wire [7:0]  reg_num_i,
  input  wire [7:0]  pointer_i,
  input  wire [31:0] stack_ptr_i,
  output wire [7:0]  abs_num_o
);
  wire [7:0] eff_num;
  wire [6:0] local_sum;

  // Number zero means the position's pointer supplies the number
  assign eff_num   = (reg_num_i == `REG_INDIRECT) ? pointer_i : reg_num_i; // [RULE4]
  // Local window: offset by stack pointer bits 8..2, wraps in seven bits
  assign local_sum = eff_num[6:0] + stack_ptr_i[8:2];                    // [RULE16]
  assign abs_num_o = eff_num[7] ? {1'b1, local_sum} : eff_num;           // [RULE15]
endmodule // reg_number_map

// ### rtl/branch_misc_regfile_exec.v
// Function
// [RULE1] Register file of 192 words holds operands and results.
// [RULE2] Each instruction names two sources and one result register.
// [RULE3] Three separate 8-bit fields give source and result register numbers.
// [RULE4] Each position selects directly or through its own pointer register.
// [RULE5] Double values use a register pair, fetched and written as one.
// [RULE6] Leading-zero op writes count of leading zeros of a word.
// [RULE7] Pointer-triple op loads all three pointers from its fields.
// [RULE8] Emulation op loads source pointers then traps on its vector.
// [RULE9] Both interrupt-return ops return; compatibility no-op does nothing.
// [RULE10] Jump-on-true redirects to target or register only if TRUE.
// [RULE11] Jump-on-false redirects to target or register only if FALSE.
// [RULE12] Float compares write TRUE or FALSE, single and double.
// [RULE13] Every branch has one delay slot executed regardless.
// [RULE14] Other floating-point ops trap to software instead of executing.
// [RULE15] Number with top bit clear selects a global register.
// [RULE16] Local index adds stack pointer bits 8..2, wraps to seven bits.
// [RULE17] Calls write aligned PC plus 8 and redirect after delay slot.
// [RULE18] Decrement-jump always decrements, branches if value was FALSE.
`timescale 1ns/1ns
`include "bmr_defs.vh"
module branch_misc_regfile_exec #(
  parameter GPR_WORDS = `GPR_WORDS
) (
  input  wire        clk_i,
  input  wire        nrst_i,
  input  wire        instr_valid_i,
  input  wire [31:0] instr_i,
  input  wire [31:0] pc_i,
  input  wire        wb_valid_i,
  input  wire [7:0]  wb_reg_i,
  input  wire        wb_double_i,
  input  wire [31:0] wb_data_hi_i,
  input  wire [31:0] wb_data_lo_i,
  output wire        wb_ready_o,
  input  wire [7:0]  dbg_reg_i,
  output reg  [31:0] dbg_data_o,
  output reg         redirect_o,
  output reg  [31:0] redirect_pc_o,
  output reg         trap_o,
  output reg  [7:0]  trap_vector_o,
  output reg         interrupt_return_op_o,
  output reg         halt_o,
  output reg  [7:0]  src_a_ptr_o,
  output reg  [7:0]  src_b_ptr_o,
  output reg  [7:0]  result_ptr_o
);
  reg  [31:0] gpr_mem [0:GPR_WORDS-1];          // [RULE1]
  reg  [31:0] stack_ptr_reg;
  reg         pend_reg;
  reg  [31:0] pend_target_reg;
  wire [7:0]  opcode;
  wire [23:0] fields;
  wire [7:0]  abs_num [0:2];
  wire [5:0]  lz_count;

  // Array index of an absolute register; gr0 and gr2..63 have no storage
  function [7:0] gpr_index;
    input [7:0] abs_n;
    begin
      gpr_index = abs_n - `REG_GLOBAL_BASE;
    end
  endfunction

  // Read of one absolute register; unimplemented numbers read as zero
  function [31:0] read_gpr;
    input [7:0]  abs_n;
    input [31:0] mem_word;
    input [31:0] sp_word;
    begin
      if (abs_n == `REG_STACK)
        read_gpr = sp_word;
      else if (abs_n >= `REG_GLOBAL_BASE)
        read_gpr = mem_word;
      else
        read_gpr = `RST_WORD;
    end
  endfunction

  // Float ordering on a 64-bit view: sign-magnitude, signed zeros equal
  function fp_gt;
    input [63:0] a;
    input [63:0] b;
    begin
      if (a[62:0] == 63'h0 && b[62:0] == 63'h0)
        fp_gt = 1'b0;
      else if (a[63] != b[63])
        fp_gt = b[63];
      else if (a[63])
        fp_gt = a[62:0] < b[62:0];
      else
        fp_gt = a[62:0] > b[62:0];
    end
  endfunction

  // Float equality on a 64-bit view, both zeros compare equal
  function fp_eq;
    input [63:0] a;
    input [63:0] b;
    begin
      fp_eq = (a == b) || (a[62:0] == 63'h0 && b[62:0] == 63'h0);
    end
  endfunction

  assign opcode = instr_i[`OPC_HI:`OPC_LO];
  // Result, source A, source B numbers, one 8-bit field each
  assign fields = instr_i[23:0];                                         // [RULE3]

  // One mapper per operand position: 0 result, 1 source A, 2 source B
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : map_gen
      reg_number_map u_map (
        .reg_num_i   (fields[23-8*g -: 8]),
        .pointer_i   ((g == 0) ? result_ptr_o : (g == 1) ? src_a_ptr_o : src_b_ptr_o),
        .stack_ptr_i (stack_ptr_reg),
        .abs_num_o   (abs_num[g])
      );
    end
  endgenerate

  // Operand fetch; the low word of a double sits in the next register
  wire [7:0]  a_lo_num = abs_num[1] + 8'h01;
  wire [7:0]  b_lo_num = abs_num[2] + 8'h01;
  wire [31:0] src_a = read_gpr(abs_num[1], gpr_mem[gpr_index(abs_num[1])],
                               stack_ptr_reg);                          // [RULE2]
  wire [31:0] src_b = read_gpr(abs_num[2], gpr_mem[gpr_index(abs_num[2])],
                               stack_ptr_reg);
  wire [31:0] src_a_lo = read_gpr(a_lo_num, gpr_mem[gpr_index(a_lo_num)], stack_ptr_reg);
  wire [31:0] src_b_lo = read_gpr(b_lo_num, gpr_mem[gpr_index(b_lo_num)], stack_ptr_reg);
  wire [63:0] op_a_dbl = {src_a, src_a_lo};                              // [RULE5]
  wire [63:0] op_b_dbl = {src_b, src_b_lo};
  // A single word rides in the high half, so one compare serves both widths
  wire        cmp_dbl  = (opcode == `OP_DEQ) || (opcode == `OP_DGE) || (opcode == `OP_DGT);
  wire [63:0] cmp_a    = cmp_dbl ? op_a_dbl : {src_a, 32'h0000_0000};
  wire [63:0] cmp_b    = cmp_dbl ? op_b_dbl : {src_b, 32'h0000_0000};

  leading_zero_count u_lzc (
    .word_i  (src_a),
    .count_o (lz_count)
  );

  // Relative target: 16-bit word offset split over result and B fields
  wire [31:0] rel_off = {{14{instr_i[23]}}, instr_i[23:16], instr_i[7:0], 2'b00};
  wire [31:0] imm_target = pc_i + rel_off;
  wire [31:0] link_addr  = {pc_i[31:2], 2'b00} + `LINK_OFFSET;
  wire        a_true     = src_a[31];   // Booleans are tested on the top bit only

  // Decode into one write, one redirect and one event per instruction
  reg         wr_en;
  reg         wr_dbl;
  reg  [7:0]  wr_num;
  reg  [31:0] wr_hi;
  reg  [31:0] wr_lo;
  reg         br_en;
  reg  [31:0] br_target;
  reg         trap_en;
  reg  [7:0]  trap_vec;
  reg         set_c;
  reg         set_ab;
  reg         interrupt_return_op_en;
  reg         halt_en;
  reg         cmp_res;
  reg         is_fp;

  always @*
  begin
    wr_en     = 1'b0;
    wr_dbl    = 1'b0;
    wr_num    = abs_num[0];
    wr_hi     = `RST_WORD;
    wr_lo     = `RST_WORD;
    br_en     = 1'b0;
    br_target = imm_target;
    trap_en   = 1'b0;
    trap_vec  = `FP_TRAP_VEC_BASE;
    set_c     = 1'b0;
    set_ab    = 1'b0;
    interrupt_return_op_en   = 1'b0;
    halt_en   = 1'b0;
    cmp_res   = 1'b0;
    is_fp     = (opcode >= `OP_FP_LO) && (opcode <= `OP_FP_HI);
    if (instr_valid_i)
    begin
      case (opcode)
        `OP_CALL, `OP_SUBROUTINE_CALL_INDIRECT_OP:
        begin
          wr_en     = 1'b1;                                            // [RULE17]
          wr_hi     = link_addr;
          br_en     = 1'b1;
          br_target = (opcode == `OP_SUBROUTINE_CALL_INDIRECT_OP) ? src_b : imm_target;
        end
        `OP_JMP, `OP_JMPI:
        begin
          br_en     = 1'b1;
          br_target = (opcode == `OP_JMPI) ? src_b : imm_target;
        end
        `OP_JUMP_ON_TRUE_OP, `OP_JUMP_ON_TRUE_INDIRECT_OP:
        begin
          br_en     = a_true;                                          // [RULE10]
          br_target = (opcode == `OP_JUMP_ON_TRUE_INDIRECT_OP) ? src_b : imm_target;
        end
        `OP_JUMP_ON_FALSE_OP, `OP_JUMP_ON_FALSE_INDIRECT_OP:
        begin
          br_en     = !a_true;                                         // [RULE11]
          br_target = (opcode == `OP_JUMP_ON_FALSE_INDIRECT_OP) ? src_b : imm_target;
        end
        `OP_JUMP_FALSE_DECREMENT_OP:
        begin
          wr_en  = 1'b1;                                               // [RULE18]
          wr_num = abs_num[1];
          wr_hi  = src_a - 32'h0000_0001;
          br_en  = !a_true;
        end
        `OP_CLZ:
        begin
          wr_en = 1'b1;                                                // [RULE6]
          wr_hi = {26'd0, lz_count};
        end
        `OP_LOAD_POINTER_TRIPLE_OP:
        begin
          set_c  = 1'b1;                                               // [RULE7]
          set_ab = 1'b1;
        end
        `OP_EMULATION_TRAP_OP:
        begin
          set_ab   = 1'b1;                                             // [RULE8]
          trap_en  = 1'b1;
          trap_vec = fields[23:16];
        end
        `OP_INTERRUPT_RETURN_OP, `OP_INTERRUPT_RETURN_COMPAT_OP:
          interrupt_return_op_en = 1'b1;                                              // [RULE9]
        `OP_INV:
          interrupt_return_op_en = 1'b0;                                              // [RULE9]
        `OP_HALT:
          halt_en = 1'b1;
        `OP_FEQ, `OP_DEQ, `OP_FGE, `OP_DGE, `OP_FGT, `OP_DGT:
        begin
          if (opcode == `OP_FEQ || opcode == `OP_DEQ)
            cmp_res = fp_eq(cmp_a, cmp_b);
          else if (opcode == `OP_FGT || opcode == `OP_DGT)
            cmp_res = fp_gt(cmp_a, cmp_b);
          else
            cmp_res = fp_gt(cmp_a, cmp_b) || fp_eq(cmp_a, cmp_b);
          wr_en = 1'b1;                                                // [RULE12]
          wr_hi = cmp_res ? `BOOL_TRUE : `BOOL_FALSE;
        end
        default:
        begin
          // Floating-point arithmetic is left to a software handler
          if (is_fp)
          begin
            trap_en  = 1'b1;                                           // [RULE14]
            trap_vec = `FP_TRAP_VEC_BASE + (opcode - `OP_FP_LO);
          end
        end
      endcase
    end
  end

  // External writeback only gets the port when no instruction is valid
  assign wb_ready_o = !instr_valid_i;

  wire        any_wr  = wr_en || (wb_valid_i && wb_ready_o);
  wire [7:0]  w_num   = wr_en ? wr_num : wb_reg_i;
  wire        w_dbl   = wr_en ? wr_dbl : wb_double_i;
  wire [31:0] w_hi    = wr_en ? wr_hi : wb_data_hi_i;
  wire [31:0] w_lo    = wr_en ? wr_lo : wb_data_lo_i;
  wire [7:0]  w_lo_n  = w_num + 8'h01;

  // Storage array; no reset, software must write before reading
  always @(posedge clk_i)
  begin
    if (any_wr && w_num >= `REG_GLOBAL_BASE)
      gpr_mem[gpr_index(w_num)] <= w_hi;
    if (any_wr && w_dbl && w_lo_n >= `REG_GLOBAL_BASE)
      gpr_mem[gpr_index(w_lo_n)] <= w_lo;                              // [RULE5]
  end

  // Stack pointer, pointers, delay-slot tracking and event outputs
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stack_ptr_reg   <= `RST_WORD;
      result_ptr_o    <= `RST_PTR;
      src_a_ptr_o     <= `RST_PTR;
      src_b_ptr_o     <= `RST_PTR;
      pend_reg        <= 1'b0;
      pend_target_reg <= `RST_WORD;
      redirect_o      <= 1'b0;
      redirect_pc_o   <= `RST_WORD;
      trap_o          <= 1'b0;
      trap_vector_o   <= 8'h00;
      interrupt_return_op_o          <= 1'b0;
      halt_o          <= 1'b0;
      dbg_data_o      <= `RST_WORD;
    end
    else
    begin
      if (any_wr && w_num == `REG_STACK)
        stack_ptr_reg <= w_hi;
      // Pointers take raw field numbers, not the mapped absolute ones
      if (set_c)
        result_ptr_o <= fields[23:16];                                 // [RULE7]
      if (set_ab)
      begin
        src_a_ptr_o <= fields[15:8];                                   // [RULE8]
        src_b_ptr_o <= fields[7:0];
      end
      // Redirect is held back until the delay-slot instruction issues
      redirect_o <= 1'b0;
      if (instr_valid_i && pend_reg)
      begin
        redirect_o    <= 1'b1;                                         // [RULE13]
        redirect_pc_o <= pend_target_reg;
        pend_reg      <= br_en;
      end
      else if (br_en)
        pend_reg <= 1'b1;
      if (br_en)
        pend_target_reg <= br_target;
      trap_o <= trap_en;
      if (trap_en)
        trap_vector_o <= trap_vec;
      interrupt_return_op_o <= interrupt_return_op_en;
      halt_o <= halt_en;
      dbg_data_o <= read_gpr(dbg_reg_i, gpr_mem[gpr_index(dbg_reg_i)], stack_ptr_reg);
    end
  end
endmodule // branch_misc_regfile_exec

// ### test/branch_misc_regfile_exec_assertions.sv
`timescale 1ns/1ns
`include "bmr_defs.vh"
module exec_checker (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        instr_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic        redirect_o,
  input wire logic        trap_o,
  input wire logic [7:0]  trap_vector_o,
  input wire logic        interrupt_return_op_o,
  input wire logic        halt_o,
  input wire logic [7:0]  src_a_ptr_o,
  input wire logic [7:0]  src_b_ptr_o,
  input wire logic [7:0]  result_ptr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Opcode classes; compares run in hardware, the rest of the float range traps
  wire [7:0] op     = instr_i[31:24];
  wire       is_rt  = instr_valid_i && (op == `OP_INTERRUPT_RETURN_OP || op == `OP_INTERRUPT_RETURN_COMPAT_OP);
  wire       is_em  = instr_valid_i && op == `OP_EMULATION_TRAP_OP;
  wire       is_cmp = op == `OP_FEQ || op == `OP_DEQ || op == `OP_FGE || op == `OP_DGE
                      || op == `OP_FGT || op == `OP_DGT;
  wire       is_fpt = instr_valid_i && op >= `OP_FP_LO && op <= `OP_FP_HI && !is_cmp;
  wire       is_trp = is_em || is_fpt;

  emu_trap_a: assert property (is_em |=> trap_o && trap_vector_o == $past(instr_i[23:16]))
    else $error("emulation trap vector wrong");
  emu_ptrs_a: assert property (is_em |=> src_a_ptr_o == $past(instr_i[15:8])
    && src_b_ptr_o == $past(instr_i[7:0]) && $stable(result_ptr_o))
    else $error("emulation pointer load wrong");
  ptr_triple_a: assert property (instr_valid_i && op == `OP_LOAD_POINTER_TRIPLE_OP |=>
    result_ptr_o == $past(instr_i[23:16]) && src_a_ptr_o == $past(instr_i[15:8])
    && src_b_ptr_o == $past(instr_i[7:0]))
    else $error("pointer triple load wrong");
  fp_trap_a: assert property (is_fpt |=> trap_o
    && trap_vector_o == `FP_TRAP_VEC_BASE + $past(op) - `OP_FP_LO)
    else $error("float opcode did not trap");
  trap_cause_a: assert property (trap_o |-> $past(is_trp))
    else $error("trap without cause");
  interrupt_return_op_pair_a: assert property (is_rt |=> interrupt_return_op_o)
    else $error("interrupt return missing");
  interrupt_return_op_cause_a: assert property (interrupt_return_op_o |-> $past(is_rt))
    else $error("interrupt return without cause");
  noop_quiet_a: assert property (instr_valid_i && op == `OP_INV |=>
    !trap_o && !interrupt_return_op_o && !halt_o)
    else $error("no-op had an effect");
  delay_slot_a: assert property (redirect_o |-> $past(instr_valid_i))
    else $error("redirect without delay slot");
endmodule // exec_checker

bind branch_misc_regfile_exec exec_checker u_exec_checker (
  .clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .redirect_o(redirect_o), .trap_o(trap_o), .trap_vector_o(trap_vector_o),
  .interrupt_return_op_o(interrupt_return_op_o), .halt_o(halt_o), .src_a_ptr_o(src_a_ptr_o),
  .src_b_ptr_o(src_b_ptr_o), .result_ptr_o(result_ptr_o));

// ### test/branch_misc_regfile_exec_tb.sv
`timescale 1ns/1ns
`include "bmr_defs.vh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module branch_misc_regfile_exec_tb;
  reg         clk_i = 0, nrst_i = 0, instr_valid_i = 0, wb_valid_i = 0, wb_double_i = 0;
  reg  [31:0] instr_i = 0, pc_i = 0, wb_data_hi_i = 0, wb_data_lo_i = 0, pc_v = 0;
  reg  [7:0]  wb_reg_i = 0, dbg_reg_i = 0;
  wire [31:0] dbg_data_o, redirect_pc_o;
  wire [7:0]  trap_vector_o, src_a_ptr_o, src_b_ptr_o, result_ptr_o;
  wire        wb_ready_o, redirect_o, trap_o, interrupt_return_op_o, halt_o;
  integer     mismatches = 0, tests_run = 0;

  // 10 MHz core clock
  always #50 clk_i = ~clk_i;

  branch_misc_regfile_exec u_branch_misc_regfile_exec (
    .clk_i(clk_i), .nrst_i(nrst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .pc_i(pc_i), .wb_valid_i(wb_valid_i), .wb_reg_i(wb_reg_i), .wb_double_i(wb_double_i),
    .wb_data_hi_i(wb_data_hi_i), .wb_data_lo_i(wb_data_lo_i), .wb_ready_o(wb_ready_o),
    .dbg_reg_i(dbg_reg_i), .dbg_data_o(dbg_data_o), .redirect_o(redirect_o),
    .redirect_pc_o(redirect_pc_o), .trap_o(trap_o), .trap_vector_o(trap_vector_o),
    .interrupt_return_op_o(interrupt_return_op_o), .halt_o(halt_o), .src_a_ptr_o(src_a_ptr_o),
    .src_b_ptr_o(src_b_ptr_o), .result_ptr_o(result_ptr_o));

  // One instruction for one cycle; returns once its registered effects have landed
  task exec(input [7:0] op, c, a, b);
    begin
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i       <= {op, c, a, b};
      pc_i          <= pc_v;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      #1;
    end
  endtask

  // Writeback only while no instruction is presented, so it is never refused
  task wr(input [7:0] n, input [31:0] hi, lo, input dbl);
    begin
      @(posedge clk_i);
      wb_valid_i   <= 1'b1;
      wb_reg_i     <= n;
      wb_double_i  <= dbl;
      wb_data_hi_i <= hi;
      wb_data_lo_i <= lo;
      @(posedge clk_i);
      wb_valid_i   <= 1'b0;
    end
  endtask

  // Observe register n on dbg_data_o one edge after selecting it
  task rd(input [7:0] n);
    begin
      @(posedge clk_i);
      dbg_reg_i <= n;
      @(posedge clk_i);
      #1;
    end
  endtask

  // Branch followed by its delay slot; the redirect may only show after the slot
  task br(input [7:0] op, c, a, b, input tk, input [31:0] tgt);
    begin
      exec(op, c, a, b);
      `CHK("early redirect", 1'b0, redirect_o)
      exec(`OP_INV, 8'h40, 8'h40, 8'h40);
      `CHK("redirect", tk, redirect_o)
      if (tk)
        `CHK("redirect pc", tgt, redirect_pc_o)
    end
  endtask

  task fpc(input [7:0] op, a, b, input [31:0] ex);
    begin
      exec(op, 8'h4C, a, b);
      rd(8'h4C);
      `CHK("compare result", ex, dbg_data_o)
    end
  endtask

  task t_clz;
    begin
      wr(8'h40, 32'h0001_0000, 32'h0000_0000, 1'b0);
      wr(8'h42, 32'h0000_0000, 32'h0000_0000, 1'b0);
      exec(`OP_CLZ, 8'h41, 8'h40, 8'h40);
      exec(`OP_CLZ, 8'h43, 8'h42, 8'h42);
      rd(8'h41);
      `CHK("zero count", 32'h0000_000F, dbg_data_o)
      rd(8'h43);
      `CHK("zero count of zero", 32'h0000_0020, dbg_data_o)
    end
  endtask

  task t_fp;
    begin
      wr(8'h50, 32'h1234_5678, 32'h9ABC_DEF0, 1'b1);
      wr(8'h52, 32'h1234_5678, 32'h9ABC_DEF1, 1'b1);
      rd(8'h50);
      `CHK("pair high", 32'h1234_5678, dbg_data_o)
      rd(8'h51);
      `CHK("pair low", 32'h9ABC_DEF0, dbg_data_o)
      wr(8'h4A, 32'h3F80_0000, 32'h0000_0000, 1'b0);
      wr(8'h4B, 32'h4000_0000, 32'h0000_0000, 1'b0);
      fpc(`OP_FGT, 8'h4B, 8'h4A, `BOOL_TRUE);
      fpc(`OP_FGT, 8'h4A, 8'h4B, `BOOL_FALSE);
      fpc(`OP_FGE, 8'h4A, 8'h4A, `BOOL_TRUE);
      fpc(`OP_FEQ, 8'h4A, 8'h4B, `BOOL_FALSE);
      fpc(`OP_DGT, 8'h52, 8'h50, `BOOL_TRUE);
      fpc(`OP_DGE, 8'h50, 8'h52, `BOOL_FALSE);
      fpc(`OP_DEQ, 8'h50, 8'h50, `BOOL_TRUE);
    end
  endtask

  task t_branch;
    begin
      wr(8'h44, `BOOL_TRUE, 32'h0000_0000, 1'b0);
      wr(8'h45, `BOOL_FALSE, 32'h0000_0000, 1'b0);
      wr(8'h46, 32'h0000_2000, 32'h0000_0000, 1'b0);
      pc_v = 32'h0000_1000;
      br(`OP_JUMP_ON_TRUE_OP, 8'h01, 8'h44, 8'h10, 1'b1, 32'h0000_1440);
      br(`OP_JUMP_ON_TRUE_OP, 8'h01, 8'h45, 8'h10, 1'b0, 32'h0000_0000);
      br(`OP_JUMP_ON_FALSE_OP, 8'hFF, 8'h45, 8'hFC, 1'b1, 32'h0000_0FF0);
      br(`OP_JUMP_ON_FALSE_OP, 8'h01, 8'h44, 8'h10, 1'b0, 32'h0000_0000);
      br(`OP_JUMP_ON_TRUE_INDIRECT_OP, 8'h40, 8'h44, 8'h46, 1'b1, 32'h0000_2000);
      br(`OP_JUMP_ON_FALSE_INDIRECT_OP, 8'h40, 8'h45, 8'h46, 1'b1, 32'h0000_2000);
      br(`OP_JUMP_ON_FALSE_INDIRECT_OP, 8'h40, 8'h44, 8'h46, 1'b0, 32'h0000_0000);
    end
  endtask

  task t_call_dec;
    begin
      pc_v = 32'h0000_1006;
      br(`OP_SUBROUTINE_CALL_INDIRECT_OP, 8'h47, 8'h40, 8'h46, 1'b1, 32'h0000_2000);
      rd(8'h47);
      `CHK("link", 32'h0000_100C, dbg_data_o)
      wr(8'h48, `BOOL_FALSE, 32'h0000_0000, 1'b0);
      pc_v = 32'h0000_1000;
      br(`OP_JUMP_FALSE_DECREMENT_OP, 8'h00, 8'h48, 8'h04, 1'b1, 32'h0000_1010);
      rd(8'h48);
      `CHK("decremented", 32'hFFFF_FFFF, dbg_data_o)
      br(`OP_JUMP_FALSE_DECREMENT_OP, 8'h00, 8'h48, 8'h04, 1'b0, 32'h0000_0000);
      rd(8'h48);
      `CHK("decremented again", 32'hFFFF_FFFE, dbg_data_o)
    end
  endtask

  task t_misc;
    begin
      exec(`OP_INTERRUPT_RETURN_OP, 8'h40, 8'h40, 8'h40);
      `CHK("return", 1'b1, interrupt_return_op_o)
      exec(`OP_INTERRUPT_RETURN_COMPAT_OP, 8'h40, 8'h40, 8'h40);
      `CHK("compat return", 1'b1, interrupt_return_op_o)
      exec(`OP_HALT, 8'h40, 8'h40, 8'h40);
      `CHK("halt", 1'b1, halt_o)
      exec(`OP_INV, 8'h40, 8'h40, 8'h40);
      `CHK("no-op return", 1'b0, interrupt_return_op_o)
      `CHK("no-op halt", 1'b0, halt_o)
    end
  endtask

  // Stack pointer 0x20C puts local 0 at absolute 0x83; reached via the source A pointer
  task t_ptr;
    begin
      wr(8'h01, 32'h0000_020C, 32'h0000_0000, 1'b0);
      wr(8'h83, 32'h0000_00FF, 32'h0000_0000, 1'b0);
      exec(`OP_LOAD_POINTER_TRIPLE_OP, 8'h4D, 8'h80, 8'h40);
      `CHK("result ptr", 8'h4D, result_ptr_o)
      `CHK("src a ptr", 8'h80, src_a_ptr_o)
      `CHK("src b ptr", 8'h40, src_b_ptr_o)
      exec(`OP_CLZ, 8'h00, 8'h00, 8'h00);
      rd(8'h4D);
      `CHK("indirect local", 32'h0000_0018, dbg_data_o)
      exec(`OP_EMULATION_TRAP_OP, 8'h25, 8'h60, 8'h61);
      `CHK("trap", 1'b1, trap_o)
      `CHK("vector", 8'h25, trap_vector_o)
      `CHK("emu a ptr", 8'h60, src_a_ptr_o)
      `CHK("emu b ptr", 8'h61, src_b_ptr_o)
      exec(`OP_FP_LO, 8'h41, 8'h40, 8'h40);
      `CHK("fp vector", `FP_TRAP_VEC_BASE, trap_vector_o)
    end
  endtask

  // Writeback offered beside an instruction is refused and leaves the register alone
  task t_refuse;
    begin
      wr(8'h4E, 32'h0000_0011, 32'h0000_0000, 1'b0);
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i       <= {`OP_INV, 8'h40, 8'h40, 8'h40};
      wb_valid_i    <= 1'b1;
      wb_reg_i      <= 8'h4E;
      wb_data_hi_i  <= 32'h0000_0022;
      #1;
      `CHK("writeback ready", 1'b0, wb_ready_o)
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      wb_valid_i    <= 1'b0;
      rd(8'h4E);
      `CHK("refused writeback", 32'h0000_0011, dbg_data_o)
    end
  endtask

  // Reset in mid-run clears the pointers; the register array keeps its contents
  task t_reset;
    begin
      @(posedge clk_i);
      nrst_i <= 1'b0;
      @(posedge clk_i);
      `CHK("reset result ptr", 8'h00, result_ptr_o)
      `CHK("reset src a ptr", 8'h00, src_a_ptr_o)
      nrst_i <= 1'b1;
      rd(8'h4D);
      `CHK("kept register", 32'h0000_0018, dbg_data_o)
    end
  endtask

  task end_of_test;
    begin
      if (mismatches == 0 && tests_run > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // Watchdog: the tests take under two hundred cycles
  initial
  begin
    #1_000_000;
    mismatches = mismatches + 1;
    end_of_test;
  end

  initial
  begin
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_clz;
    t_fp;
    t_branch;
    t_call_dec;
    t_misc;
    t_ptr;
    t_refuse;
    t_reset;
    end_of_test;
  end
endmodule // branch_misc_regfile_exec_tb
